// ==== shared/iacc_pkg.sv ====
package iacc_pkg;

    // Register offsets on the management port
    localparam logic [4:0] OFF_CTRL     = 5'h0D;
    localparam logic [4:0] OFF_WINDOW   = 5'h0E;
    localparam logic [4:0] OFF_DROP     = 5'h0F;
    localparam logic [4:0] OFF_STATUS   = 5'h10;
    localparam logic [4:0] OFF_RXERRCNT = 5'h15;
    localparam logic [4:0] OFF_TENMEG   = 5'h1A;

    // Reset values
    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [15:0] WINDOW_RST = 16'h0000;
    localparam logic [4:0]  DROP_RST   = 5'h00;
    localparam logic [15:0] MEM_RST    = 16'h0000;

    // Field positions
    localparam int CMD_LSB       = 14;
    localparam int SPACE_W       = 5;
    localparam int DROP_LSB      = 4;
    localparam int ST_XOVER_BIT  = 14;
    localparam int ST_RXERR_BIT  = 13;
    localparam int ST_POL_BIT    = 12;
    localparam int TENMEG_POL_BIT = 4;

    // Space select codes
    localparam logic [4:0] SPACE_VENDOR = 5'h1F;
    localparam logic [4:0] SPACE_MMD3   = 5'h03;
    localparam logic [4:0] SPACE_MMD7   = 5'h07;
    localparam int         NUM_SPACES   = 3;

    // Vendor space reaches address 0x04D1 inclusive
    localparam int VENDOR_DEPTH = 16'h04D2;
    localparam int MMD_DEPTH    = 64;

    // Link drop cause bit positions
    localparam int FLD_ENERGY = 0;
    localparam int FLD_SNR    = 1;
    localparam int FLD_MLT3   = 2;
    localparam int FLD_RXERR  = 3;
    localparam int FLD_DESCR  = 4;
    localparam int FLD_NUM    = 5;

    // Fast link-down reaction time
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int FLD_REACT_NS   = 10000;
    localparam int FLD_REACT_CYC  = (FLD_REACT_NS * 1000) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        CMD_ADDR,
        CMD_DATA,
        CMD_DATA_INC_RW,
        CMD_DATA_INC_WR
    } iacc_cmd_t;

    typedef enum logic [1:0] {
        SP_VENDOR,
        SP_MMD3,
        SP_MMD7,
        SP_NONE
    } iacc_space_t;

endpackage

// ==== shared/iacc_mmd_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface iacc_mmd_if;
    logic        addr_we;
    logic        data_we;
    logic        inc;
    logic [15:0] wdata;
    logic [15:0] addr;
    logic [15:0] rdata;

    modport ctl (
        output addr_we,
        output data_we,
        output inc,
        output wdata,
        input  addr,
        input  rdata
    );

    modport store (
        input  addr_we,
        input  data_we,
        input  inc,
        input  wdata,
        output addr,
        output rdata
    );
endinterface

`default_nettype wire

// ==== core/iacc_mmd_store.sv ====
`timescale 1ns/1ps
`default_nettype none

module iacc_mmd_store #(
    parameter int DEPTH = 64
) (
    input  wire logic   i_mclk,
    input  wire logic   i_resetn,
    iacc_mmd_if.store   mmd
);
    import iacc_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [15:0] mem [DEPTH];
    logic [15:0] addr_r;
    logic        in_range;

    assign in_range = (addr_r < 16'(DEPTH));

    // Held address, loaded or advanced
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            addr_r <= WINDOW_RST;
        end else if (mmd.addr_we) begin
            addr_r <= mmd.wdata;
        end else if (mmd.inc) begin
            addr_r <= addr_r + 16'h0001;
        end
    end

    // Writes past the top of the space are dropped
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= MEM_RST;
            end
        end else if (mmd.data_we && in_range) begin
            mem[addr_r[AW-1:0]] <= mmd.wdata;
        end
    end

    assign mmd.addr  = addr_r;
    assign mmd.rdata = in_range ? mem[addr_r[AW-1:0]] : 16'h0000;

endmodule // iacc_mmd_store

`default_nettype wire

// ==== core/iacc_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module iacc_top #(
    parameter int VENDOR_DEPTH = iacc_pkg::VENDOR_DEPTH,
    parameter int MMD_DEPTH    = iacc_pkg::MMD_DEPTH,
    parameter int REACT_CYC    = iacc_pkg::FLD_REACT_CYC
) (
    input  wire logic                         i_mclk,
    input  wire logic                         i_resetn,
    input  wire logic [4:0]                   i_addr,
    input  wire logic [15:0]                  i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [15:0]                  o_rdata,
    input  wire logic                         i_crossover,
    input  wire logic                         i_rx_error_evt,
    input  wire logic                         i_polarity_inv,
    input  wire logic                         i_link_up,
    input  wire logic [iacc_pkg::FLD_NUM-1:0] i_fld_enable,
    input  wire logic [iacc_pkg::FLD_NUM-1:0] i_fld_cond,
    output logic                              o_link_drop
);
    import iacc_pkg::*;

    function automatic iacc_space_t space_of(input logic [4:0] sel);
        if (sel == SPACE_VENDOR) begin
            return SP_VENDOR;
        end else if (sel == SPACE_MMD3) begin
            return SP_MMD3;
        end else if (sel == SPACE_MMD7) begin
            return SP_MMD7;
        end else begin
            return SP_NONE;
        end
    endfunction

    function automatic logic is_inc(input iacc_cmd_t c, input logic wr);
        return (c == CMD_DATA_INC_RW) || (wr && c == CMD_DATA_INC_WR);
    endfunction

    localparam int CW = $clog2(REACT_CYC + 1);

    iacc_cmd_t            cmd_r;
    logic [SPACE_W-1:0]   space_r;
    iacc_space_t          sp;
    logic                 sp_ok;
    logic                 win_wr;
    logic                 win_rd;
    logic [15:0]          sp_addr  [NUM_SPACES];
    logic [15:0]          sp_rdata [NUM_SPACES];
    logic [15:0]          sel_addr;
    logic [15:0]          sel_rdata;
    logic [15:0]          rd_mux;
    logic [15:0]          rdata_r;
    logic                 xover_r;
    logic                 rx_err_r;
    logic                 pol_r;
    logic [FLD_NUM-1:0]   cause_r;
    logic [FLD_NUM-1:0]   fld_hit;
    logic                 fld_trig;
    logic [CW-1:0]        fld_cnt_r;
    logic                 drop_nxt;
    logic                 drop_r;

    assign sp      = space_of(space_r);
    assign sp_ok   = (sp != SP_NONE);
    assign win_wr  = i_wr && (i_addr == OFF_WINDOW);
    assign win_rd  = i_rd && (i_addr == OFF_WINDOW);

    // Control register
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd_r   <= iacc_cmd_t'(CTRL_RST[CMD_LSB +: 2]);
            space_r <= CTRL_RST[SPACE_W-1:0];
        end else if (i_wr && i_addr == OFF_CTRL) begin
            cmd_r   <= iacc_cmd_t'(i_wdata[CMD_LSB +: 2]);
            space_r <= i_wdata[SPACE_W-1:0];
        end
    end

    iacc_mmd_if mmd_if [NUM_SPACES] ();

    generate
        for (genvar g = 0; g < NUM_SPACES; g++) begin : g_space
            logic hit;
            assign hit = sp_ok && (int'(sp) == g);
            assign mmd_if[g].addr_we = hit && win_wr && (cmd_r == CMD_ADDR);
            assign mmd_if[g].data_we = hit && win_wr && (cmd_r != CMD_ADDR);
            assign mmd_if[g].inc     = hit && ((win_wr && is_inc(cmd_r, 1'b1))
                                       || (win_rd && is_inc(cmd_r, 1'b0)));
            assign mmd_if[g].wdata   = i_wdata;
            assign sp_addr[g]        = mmd_if[g].addr;
            assign sp_rdata[g]       = mmd_if[g].rdata;

            iacc_mmd_store #(
                .DEPTH (g == 0 ? VENDOR_DEPTH : MMD_DEPTH)
            ) u_store (
                .i_mclk   (i_mclk),
                .i_resetn (i_resetn),
                .mmd      (mmd_if[g])
            );
        end
    endgenerate

    // Selected space view
    always_comb begin
        sel_addr  = 16'h0000;
        sel_rdata = 16'h0000;
        for (int k = 0; k < NUM_SPACES; k++) begin
            if (sp_ok && int'(sp) == k) begin
                sel_addr  = sp_addr[k];
                sel_rdata = sp_rdata[k];
            end
        end
    end

    // Read multiplexer
    always_comb begin
        rd_mux = 16'h0000;
        if (i_addr == OFF_CTRL) begin
            rd_mux = {cmd_r, 9'h000, space_r};
        end else if (i_addr == OFF_WINDOW) begin
            if (sp_ok) begin
                rd_mux = (cmd_r == CMD_ADDR) ? sel_addr : sel_rdata;
            end
        end else if (i_addr == OFF_DROP) begin
            rd_mux[DROP_LSB +: FLD_NUM] = cause_r;
        end else if (i_addr == OFF_STATUS) begin
            rd_mux[ST_XOVER_BIT] = xover_r;
            rd_mux[ST_RXERR_BIT] = rx_err_r;
            rd_mux[ST_POL_BIT]   = pol_r;
        end else if (i_addr == OFF_TENMEG) begin
            rd_mux[TENMEG_POL_BIT] = pol_r;
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_r <= 16'h0000;
        end else if (i_rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign o_rdata = rdata_r;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            xover_r <= 1'b0;
        end else begin
            xover_r <= i_crossover;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_err_r <= 1'b0;
        end else if (i_rx_error_evt) begin
            rx_err_r <= 1'b1;
        end else if (i_rd && i_addr == OFF_RXERRCNT) begin
            rx_err_r <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            pol_r <= 1'b0;
        end else if (i_polarity_inv) begin
            pol_r <= 1'b1;
        end else if (i_rd && i_addr == OFF_TENMEG) begin
            pol_r <= 1'b0;
        end
    end

    assign fld_hit  = i_fld_enable & i_fld_cond;
    assign fld_trig = i_link_up && (|fld_hit);
    assign drop_nxt = fld_trig && (fld_cnt_r == CW'(REACT_CYC - 1));

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            fld_cnt_r <= '0;
        end else if (!fld_trig || drop_nxt) begin
            fld_cnt_r <= '0;
        end else begin
            fld_cnt_r <= fld_cnt_r + CW'(1);
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            drop_r <= 1'b0;
        end else begin
            drop_r <= drop_nxt;
        end
    end

    assign o_link_drop = drop_r;

    // cause latch, set wins over read clear
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cause_r <= DROP_RST;
        end else if (drop_nxt) begin
            cause_r <= cause_r | fld_hit;
        end else if (i_rd && i_addr == OFF_DROP) begin
            cause_r <= DROP_RST;
        end
    end

    property p_rxerr_set;
        @(posedge i_mclk) disable iff (!i_resetn)
        i_rx_error_evt |=> rx_err_r;
    endproperty
    a_rxerr_set: assert property (p_rxerr_set)
        else $error("receive error latch did not set");

    property p_rxerr_clr;
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_rd && i_addr == OFF_RXERRCNT && !i_rx_error_evt)
            |=> !rx_err_r;
    endproperty
    a_rxerr_clr: assert property (p_rxerr_clr)
        else $error("receive error latch not cleared by counter read");

    property p_pol_keep;
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_rd && i_addr == OFF_STATUS && pol_r) |=> pol_r;
    endproperty
    a_pol_keep: assert property (p_pol_keep)
        else $error("status read cleared polarity latch");

    property p_pol_clr;
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_rd && i_addr == OFF_TENMEG && !i_polarity_inv)
            |=> !pol_r ##1 (!pol_r || $past(i_polarity_inv));
    endproperty
    a_pol_clr: assert property (p_pol_clr)
        else $error("polarity latch not cleared by ten meg read");

    property p_xover_read;
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_rd && i_addr == OFF_STATUS)
            |=> o_rdata[ST_XOVER_BIT] == $past(xover_r);
    endproperty
    a_xover_read: assert property (p_xover_read)
        else $error("crossover bit wrong in status read");

    property p_bad_space;
        @(posedge i_mclk) disable iff (!i_resetn)
        ((win_wr || win_rd) && !sp_ok)
            |=> $stable(sp_addr[0]) && $stable(sp_addr[1])
                && $stable(sp_addr[2]);
    endproperty
    a_bad_space: assert property (p_bad_space)
        else $error("access with unsupported space changed state");

    property p_addr_load;
        @(posedge i_mclk) disable iff (!i_resetn)
        (win_wr && sp_ok && cmd_r == CMD_ADDR)
            |=> sel_addr == $past(i_wdata);
    endproperty
    a_addr_load: assert property (p_addr_load)
        else $error("window write did not load held address");

    property p_post_inc;
        @(posedge i_mclk) disable iff (!i_resetn)
        (win_wr && sp_ok && cmd_r == CMD_DATA_INC_WR)
            |=> sel_addr == $past(sel_addr) + 16'h0001;
    endproperty
    a_post_inc: assert property (p_post_inc)
        else $error("held address did not advance after write");

    property p_no_inc;
        @(posedge i_mclk) disable iff (!i_resetn)
        (win_rd && sp_ok && cmd_r == CMD_DATA_INC_WR) |=> $stable(sel_addr);
    endproperty
    a_no_inc: assert property (p_no_inc)
        else $error("read advanced address in write-only increment mode");

    property p_mmd_read;
        @(posedge i_mclk) disable iff (!i_resetn)
        (win_rd && sp_ok && cmd_r != CMD_ADDR)
            |=> o_rdata == $past(sel_rdata);
    endproperty
    a_mmd_read: assert property (p_mmd_read)
        else $error("window read did not return selected space data");

    property p_drop_cause;
        @(posedge i_mclk) disable iff (!i_resetn)
        drop_nxt |=> o_link_drop && ((cause_r & $past(fld_hit))
            == $past(fld_hit));
    endproperty
    a_drop_cause: assert property (p_drop_cause)
        else $error("link drop cause bits not latched");

    property p_drop_needs_trig;
        @(posedge i_mclk) disable iff (!i_resetn)
        !fld_trig |=> !o_link_drop;
    endproperty
    a_drop_needs_trig: assert property (p_drop_needs_trig)
        else $error("link drop without enabled condition");

    property p_tenmeg_read;
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_rd && i_addr == OFF_TENMEG)
            |=> o_rdata[TENMEG_POL_BIT] == $past(pol_r);
    endproperty
    a_tenmeg_read: assert property (p_tenmeg_read)
        else $error("polarity bit wrong in ten meg read");

endmodule // iacc_top

`default_nettype wire

// ==== test/iacc_sta.sv ====
`timescale 1ns/1ps
`default_nettype none

module iacc_sta (
    input  wire logic        i_mclk,
    output var  logic [4:0]  o_addr,
    output var  logic [15:0] o_wdata,
    output var  logic        o_wr,
    output var  logic        o_rd,
    input  wire logic [15:0] i_rdata
);
    import iacc_pkg::*;

    initial begin
        o_addr  = 5'h00;
        o_wdata = 16'h0000;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end

    // Released data lines show the inverse, never stale data; the address is held after a write and inverted after a read
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_mclk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_mclk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask

    task automatic ctl(input iacc_cmd_t c, input logic [4:0] s);
        wr(OFF_CTRL, {c, 9'h000, s});
    endtask
endmodule // iacc_sta

`default_nettype wire

// ==== test/iacc_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module iacc_bench;
    import iacc_pkg::*;

    localparam int REACT = 8;

    logic        mclk;
    logic        resetn;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        crossover;
    logic        rx_err;
    logic        pol;
    logic        link_up;
    logic [4:0]  fld_en;
    logic [4:0]  fld_cond;
    logic        link_drop;
    logic        seen;
    logic [4:0]  sp [3];
    int          n;
    int          fails;
    int          cmp_count;

    iacc_top #(.REACT_CYC(REACT)) DUT (
        .i_mclk         (mclk),
        .i_resetn       (resetn),
        .i_addr         (addr),
        .i_wdata        (wdata),
        .i_wr           (wr),
        .i_rd           (rd),
        .o_rdata        (rdata),
        .i_crossover    (crossover),
        .i_rx_error_evt (rx_err),
        .i_polarity_inv (pol),
        .i_link_up      (link_up),
        .i_fld_enable   (fld_en),
        .i_fld_cond     (fld_cond),
        .o_link_drop    (link_drop)
    );

    iacc_sta u_sta (
        .i_mclk  (mclk),
        .o_addr  (addr),
        .o_wdata (wdata),
        .o_wr    (wr),
        .o_rd    (rd),
        .i_rdata (rdata)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rc(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_sta.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask

    initial begin
        #250000;
        fails++;
        print_verdict();
    end

    initial begin
        fails = 0;
        cmp_count = 0;
        sp = '{SPACE_MMD3, SPACE_MMD7, 5'h02};
        resetn = 1'b0;
        crossover = 1'b0;
        rx_err = 1'b0;
        pol = 1'b0;
        link_up = 1'b0;
        fld_en = 5'h00;
        fld_cond = 5'h00;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        rc(OFF_CTRL, CTRL_RST);
        rc(OFF_WINDOW, WINDOW_RST);
        u_sta.wr(OFF_DROP, 16'hFFFF);
        u_sta.wr(OFF_STATUS, 16'hFFFF);
        rc(OFF_DROP, 16'h0000);
        rc(OFF_STATUS, 16'h0000);
        rc(5'h03, 16'h0000);
        u_sta.ctl(CMD_ADDR, SPACE_VENDOR);
        rc(OFF_CTRL, 16'h001F);
        u_sta.wr(OFF_WINDOW, 16'h04D1);
        rc(OFF_WINDOW, 16'h04D1);
        u_sta.ctl(CMD_DATA, SPACE_VENDOR);
        u_sta.wr(OFF_WINDOW, 16'hBEEF);
        rc(OFF_WINDOW, 16'hBEEF);
        rc(OFF_WINDOW, 16'hBEEF);
        u_sta.ctl(CMD_ADDR, SPACE_VENDOR);
        u_sta.wr(OFF_WINDOW, 16'h04D2);
        u_sta.ctl(CMD_DATA, SPACE_VENDOR);
        u_sta.wr(OFF_WINDOW, 16'hDEAD);
        rc(OFF_WINDOW, 16'h0000);
        for (int c = 2; c < 4; c++) begin
            u_sta.ctl(CMD_ADDR, SPACE_VENDOR);
            u_sta.wr(OFF_WINDOW, 16'h0020);
            u_sta.ctl(iacc_cmd_t'(c), SPACE_VENDOR);
            u_sta.wr(OFF_WINDOW, 16'(16'hA000 + c));
            u_sta.wr(OFF_WINDOW, 16'(16'hB000 + c));
            rc(OFF_WINDOW, 16'h0000);
            u_sta.ctl(CMD_ADDR, SPACE_VENDOR);
            rc(OFF_WINDOW, (c == 2) ? 16'h0023 : 16'h0022);
        end
        u_sta.wr(OFF_WINDOW, 16'h0020);
        u_sta.ctl(CMD_DATA_INC_RW, SPACE_VENDOR);
        rc(OFF_WINDOW, 16'hA003);
        rc(OFF_WINDOW, 16'hB003);
        for (int s = 0; s < 3; s++) begin
            u_sta.ctl(CMD_ADDR, sp[s]);
            u_sta.wr(OFF_WINDOW, 16'h0005);
            u_sta.ctl(CMD_DATA, sp[s]);
            u_sta.wr(OFF_WINDOW, 16'(16'h3000 + s));
        end
        for (int s = 0; s < 3; s++) begin
            u_sta.ctl(CMD_DATA, sp[s]);
            rc(OFF_WINDOW, (s == 2) ? 16'h0000 : 16'(16'h3000 + s));
        end
        u_sta.ctl(CMD_ADDR, SPACE_VENDOR);
        rc(OFF_WINDOW, 16'h0022);
        u_sta.wr(OFF_WINDOW, 16'h0005);
        u_sta.ctl(CMD_DATA, SPACE_VENDOR);
        rc(OFF_WINDOW, 16'h0000);
        @(posedge mclk);
        crossover <= 1'b1;
        rx_err <= 1'b1;
        pol <= 1'b1;
        @(posedge mclk);
        rx_err <= 1'b0;
        pol <= 1'b0;
        repeat (2) @(posedge mclk);
        rc(OFF_STATUS, 16'h7000);
        rc(OFF_STATUS, 16'h7000);
        rc(OFF_RXERRCNT, 16'h0000);
        rc(OFF_STATUS, 16'h5000);
        rc(OFF_TENMEG, 16'h0010);
        rc(OFF_STATUS, 16'h4000);
        @(posedge mclk);
        crossover <= 1'b0;
        repeat (2) @(posedge mclk);
        rc(OFF_STATUS, 16'h0000);
        @(posedge mclk);
        link_up <= 1'b1;
        fld_cond <= 5'h1F;
        seen = 1'b0;
        repeat (3 * REACT) begin
            @(posedge mclk);
            #1;
            seen = seen | link_drop;
        end
        chk("drop disabled", 16'h0000, {15'h0000, seen});
        for (int i = 0; i < FLD_NUM; i++) begin
            @(posedge mclk);
            fld_en <= 5'(1 << i);
            n = 0;
            while (link_drop !== 1'b1) begin
                @(posedge mclk);
                #1;
                n++;
                if (n > 5 * REACT) begin
                    fails++;
                    print_verdict();
                end
            end
            @(posedge mclk);
            fld_en <= 5'h00;
            chk("react", 16'h0001, 16'(n >= REACT && n <= REACT + 1));
            rc(OFF_DROP, 16'(1 << (i + DROP_LSB)));
            rc(OFF_DROP, 16'h0000);
        end
        print_verdict();
    end
endmodule // iacc_bench

`default_nettype wire
